// ### pwg_chk.sv
// Purpose: port-level checks of the write guard and undervoltage response
// Assumes: one command strobe per complete write
// Notes:   bound to every instance of the guard
module pwg_chk
   import pwg_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] read_code,
   input wire logic [7:0] read_data,
   input wire logic       write_accepted,
   input wire logic       write_rejected,
   input wire logic       output_enable,
   input wire logic       alert_output_n,
   input wire logic       undervolt_fault_status
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ****************************************
   // sequences and properties
   // ****************************************
   sequence s_reject_resp;
      write_rejected && read_code == cmd_monitor_undervolt;
   endsequence
   sequence s_read_resp;
      read_code == cmd_monitor_undervolt && !cmd_write;
   endsequence
   a_one_answer: assert property (cmd_write == (write_accepted ^ write_rejected)
      && !(write_accepted && write_rejected)) else $error("bad write answer");
   a_tier_readonly: assert property (cmd_write && cmd_code == cmd_access_tier
      |-> write_rejected) else $error("tier byte written");
   a_password_open: assert property (cmd_write && (cmd_code == cmd_private_password
      || cmd_code == cmd_public_password || cmd_code == cmd_clear_faults)
      |-> write_accepted) else $error("open command refused");
   a_status_sticky: assert property (undervolt_fault_status && !(write_accepted
      && cmd_code == cmd_clear_faults) |=> undervolt_fault_status) else $error("status lost");
   a_alert_status: assert property (alert_output_n == !undervolt_fault_status)
      else $error("alert and status differ");
   a_drop_alerts: assert property ($fell(output_enable) |=> ##[0:2] !alert_output_n)
      else $error("shutdown without alert");
   a_tier_range: assert property (read_code == cmd_access_tier |=> read_data <= tier_vendor)
      else $error("tier out of range");
   a_reject_keeps: assert property (s_reject_resp ##1 s_read_resp |=> $stable(read_data))
      else $error("rejected write changed value");
endmodule : pwg_chk

bind pwg_guard pwg_chk pwg_chk_i (.ref_clk, .reset, .cmd_write, .cmd_code, .read_code,
   .read_data, .write_accepted, .write_rejected, .output_enable, .alert_output_n,
   .undervolt_fault_status);

// ### pwg_guard.sv
// Operation
// - mode 00 ignores, 10 disables, retries only at retry 111
// - mode 11 holds off until recovery
// - responded fault pulls alert, sets status
// - fault bit cleared only by clear_faults
// - retry 000 keeps output off
// - retry 111 restarts continuously
// - continuous retry waits for recovery level
// - retry spacing is (delay+1) times 35ms
// - response byte rw, protected, resets bfh
// - reads always allowed, permit bit per command
// - protected write changes nothing without password
// - each store has own map, password
// - default-cleared command needs default password
// - user-cleared command needs user password
// - four tiers, public reaches 0 or 1
// - private only raises, public sets 0/1
// - tier byte read-only, resets 01h
// - default password raises tier to 3
// - user password raises tier to 2
// - wrong public password drops tier to 0
// - command n maps to permit bit n
//
// Purpose: command write guard plus monitored undervoltage fault response
// Assumes: a command decoder presents one write strobe per complete command,
//          password and permit stores are presented as level inputs,
//          undervoltage and recovery comparisons are made outside
// Notes:   permit maps are written by their own commands elsewhere
module pwg_guard
   import pwg_pkg::*;
(
   input  wire logic                          ref_clk,
   input  wire logic                          reset,
   input  wire logic                          cmd_write,
   input  wire logic [7:0]                    cmd_code,
   input  wire logic [private_pw_bits-1:0]    cmd_data,
   input  wire logic [7:0]                    read_code,
   output logic      [7:0]                    read_data,
   output logic                               write_accepted,
   output logic                               write_rejected,
   input  wire logic [permit_map_bits-1:0]    default_permit_map,
   input  wire logic [permit_map_bits-1:0]    user_permit_map,
   input  wire logic [private_pw_bits-1:0]    default_private_pw,
   input  wire logic [private_pw_bits-1:0]    user_private_pw,
   input  wire logic [public_pw_bits-1:0]     user_public_pw,
   input  wire logic                          undervolt_pin,
   input  wire logic                          recovered_pin,
   input  wire logic                          commanded_off,
   input  wire logic                          other_fault,
   output logic                               output_enable,
   output logic                               alert_output_n,
   output logic                               undervolt_fault_status
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   // three stages, a change counts once the last two agree
   logic [2:0] uv_sync;
   logic [2:0] ok_sync;
   logic       uv_level;
   logic       ok_level;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         uv_sync <= 3'h0;
         ok_sync <= 3'h0;
      end else begin
         uv_sync <= {uv_sync[1:0], undervolt_pin};
         ok_sync <= {ok_sync[1:0], recovered_pin};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         uv_level <= 1'b0;
         ok_level <= 1'b0;
      end else begin
         if (uv_sync[2] == uv_sync[1]) begin
            uv_level <= uv_sync[2];
         end
         if (ok_sync[2] == ok_sync[1]) begin
            ok_level <= ok_sync[2];
         end
      end
   end

   // ****************************************
   // write permission
   // ****************************************
   logic [7:0] monitor_undervolt_response;
   logic [7:0] access_tier_level;
   logic       default_bit;
   logic       user_bit;
   logic       always_writable;
   logic       permitted;

   assign default_bit = default_permit_map[cmd_code];
   assign user_bit    = user_permit_map[cmd_code];

   // passwords, clear_faults and the permit map write are never protected
   assign always_writable = (cmd_code == cmd_public_password) ||
                            (cmd_code == cmd_private_password) ||
                            (cmd_code == cmd_clear_faults) ||
                            (cmd_code == cmd_write_permit_map);

   always_comb begin
      if (always_writable) begin
         permitted = 1'b1;
      end else if (!default_bit) begin
         permitted = (access_tier_level >= tier_vendor);
      end else if (!user_bit) begin
         permitted = (access_tier_level >= tier_user);
      end else begin
         permitted = (access_tier_level >= tier_public);
      end
   end

   assign write_accepted = cmd_write && permitted && (cmd_code != cmd_access_tier);
   assign write_rejected = cmd_write && !write_accepted;

   // ****************************************
   // access tier
   // ****************************************
   logic [7:0] next_tier;

   always_comb begin
      next_tier = access_tier_level;
      if (write_accepted && cmd_code == cmd_public_password) begin
         if (cmd_data[public_pw_bits-1:0] == user_public_pw) begin
            next_tier = tier_public;
         end else begin
            next_tier = tier_locked;
         end
      end else if (write_accepted && cmd_code == cmd_private_password) begin
         if (cmd_data == default_private_pw) begin
            next_tier = tier_vendor;
         end else if (cmd_data == user_private_pw &&
                      access_tier_level < tier_user) begin
            next_tier = tier_user;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         access_tier_level <= access_tier_reset;
      end else begin
         access_tier_level <= next_tier;
      end
   end

   // ****************************************
   // response setting
   // ****************************************
   // protected rw byte
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         monitor_undervolt_response <= uv_response_reset;
      end else if (write_accepted && cmd_code == cmd_monitor_undervolt) begin
         monitor_undervolt_response <= cmd_data[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         read_data <= 8'h00;
      end else begin
         case (read_code)
            cmd_monitor_undervolt: read_data <= monitor_undervolt_response;
            cmd_access_tier:       read_data <= access_tier_level;
            default:               read_data <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // fault response
   // ****************************************
   typedef enum logic [4:0] {
      st_run     = 5'h01,
      st_hold    = 5'h02,
      st_latched = 5'h04,
      st_wait_ok = 5'h08,
      st_delay   = 5'h10
   } pwg_state_type;

   pwg_state_type              state;
   logic [1:0]                 resp_mode;
   logic [2:0]                 retry_set;
   logic [2:0]                 retry_delay;
   logic [retry_cnt_bits-1:0]  delay_count;
   logic [retry_cnt_bits-1:0]  delay_target;
   logic                       fault_event;
   logic                       clear_cmd;

   assign resp_mode   = monitor_undervolt_response[resp_mode_hi:resp_mode_lo];
   assign retry_set   = monitor_undervolt_response[retry_set_hi:retry_set_lo];
   assign retry_delay = monitor_undervolt_response[retry_delay_hi:retry_delay_lo];
   assign clear_cmd   = write_accepted && (cmd_code == cmd_clear_faults);

   assign delay_target = retry_cnt_bits'(({29'h0, retry_delay} + 32'h1) *
                                         retry_cnt_bits'(retry_unit_cycles));

   assign fault_event = uv_level && (state == st_run) && (resp_mode != mode_ignore) &&
                        (resp_mode != 2'h1);

   // only clear_faults clears; a new fault wins
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         undervolt_fault_status <= 1'b0;
      end else if (fault_event) begin
         undervolt_fault_status <= 1'b1;
      end else if (clear_cmd) begin
         undervolt_fault_status <= 1'b0;
      end
   end

   assign alert_output_n = !undervolt_fault_status;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state       <= st_run;
         delay_count <= 32'h0;
      end else begin
         case (state)
            st_run: begin
               delay_count <= 32'h0;
               if (fault_event) begin
                  if (resp_mode == mode_hold_until_ok) begin
                     state <= st_hold;
                  end else if (retry_set == retry_continuous) begin
                     state <= st_wait_ok;
                  end else begin
                     state <= st_latched;
                  end
               end
            end
            st_hold: begin
               if (ok_level) begin
                  state <= st_run;
               end
            end
            st_latched: begin
               if (clear_cmd) begin
                  state <= st_run;
               end
            end
            st_wait_ok: begin
               delay_count <= 32'h0;
               if (commanded_off || other_fault) begin
                  state <= st_latched;
               end else if (ok_level) begin
                  state <= st_delay;
               end
            end
            st_delay: begin
               if (commanded_off || other_fault) begin
                  state <= st_latched;
               end else if (delay_count + 32'h1 >= delay_target) begin
                  state <= st_run;
               end else begin
                  delay_count <= delay_count + 32'h1;
               end
            end
            default: state <= st_run;
         endcase
      end
   end

   assign output_enable = (state == st_run) && !fault_event;

endmodule : pwg_guard

// ### pwg_host.sv
// Purpose: bus host model issuing command writes and reads
// Assumes: called just after a rising edge
// Notes:   released payload shows inverted data, never the last value
module pwg_host
   import pwg_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic [7:0]  read_data,
   input  wire logic        write_accepted,
   output logic             cmd_write,
   output logic      [7:0]  cmd_code,
   output logic      [71:0] cmd_data,
   output logic      [7:0]  read_code
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_data = '0;
      read_code = 8'h00;
   end
   // host holds the write strobe for one edge, then idles one more cycle
   task automatic write(input logic [7:0] code, input logic [71:0] data, output logic acc);
      cmd_code = code;
      cmd_data = data;
      cmd_write = 1'b1;
      @(posedge ref_clk);
      acc = write_accepted;
      #1 cmd_write = 1'b0;
      cmd_data = ~data;
      @(posedge ref_clk);
      #1;
   endtask : write
   task automatic read(input logic [7:0] code, output logic [7:0] val);
      read_code = code;
      @(posedge ref_clk);
      #1 val = read_data;
   endtask : read
endmodule : pwg_host

// ### pwg_pkg.sv
// Purpose: shared constants for the write guard and undervoltage response block
// Assumes: command codes are one byte, passwords arrive as whole values
// Notes:   all offsets, resets and timing counts are named here
package pwg_pkg;

   // ****************************************
   // command codes
   // ****************************************
   localparam logic [7:0] cmd_clear_faults        = 8'h03;
   localparam logic [7:0] cmd_monitor_undervolt   = 8'hf9;
   localparam logic [7:0] cmd_access_tier         = 8'hfa;
   localparam logic [7:0] cmd_private_password    = 8'hfb;
   localparam logic [7:0] cmd_public_password     = 8'hfc;
   localparam logic [7:0] cmd_write_permit_map    = 8'hfd;

   // ****************************************
   // reset values and field layout
   // ****************************************
   localparam logic [7:0] uv_response_reset       = 8'hbf;
   localparam logic [7:0] access_tier_reset       = 8'h01;
   localparam int         resp_mode_hi            = 7;
   localparam int         resp_mode_lo            = 6;
   localparam int         retry_set_hi            = 5;
   localparam int         retry_set_lo            = 3;
   localparam int         retry_delay_hi          = 2;
   localparam int         retry_delay_lo          = 0;
   localparam logic [1:0] mode_ignore             = 2'h0;
   localparam logic [1:0] mode_disable_retry      = 2'h2;
   localparam logic [1:0] mode_hold_until_ok      = 2'h3;
   localparam logic [2:0] retry_none              = 3'h0;
   localparam logic [2:0] retry_continuous        = 3'h7;

   // ****************************************
   // access tiers and password widths
   // ****************************************
   localparam logic [7:0] tier_locked             = 8'h00;
   localparam logic [7:0] tier_public             = 8'h01;
   localparam logic [7:0] tier_user               = 8'h02;
   localparam logic [7:0] tier_vendor             = 8'h03;
   localparam int         private_pw_bits         = 72;
   localparam int         public_pw_bits          = 32;
   localparam int         permit_map_bits         = 256;

   // ****************************************
   // timing
   // ****************************************
   localparam int         clk_hz                  = 125000000;
   localparam int         retry_unit_ms           = 35;
   localparam int         retry_unit_cycles       = clk_hz / 1000 * retry_unit_ms;
   localparam int         retry_cnt_bits          = 32;

endpackage : pwg_pkg

// ### tb_top.sv
// Purpose: self-checking bench for the write guard
// Assumes: retry delays too long to run, so only hold-off is timed
// Notes:   fault pins are driven as already-compared levels
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pwg_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, cmd_write, write_accepted, write_rejected;
   logic [7:0] cmd_code, read_code, read_data;
   logic [71:0] cmd_data;
   logic [255:0] dmap = '1, umap = '1;
   // arbitrary password values
   logic [71:0] dpw = 72'h5a5a5a5a5a5a5a5a5a, upw = 72'h3c3c3c3c3c3c3c3c3c;
   logic [31:0] ppw = 32'h1234abcd;
   logic pin = 1'b0, rec = 1'b0, cmd_off = 1'b0;
   logic output_enable, alert_output_n, undervolt_fault_status;
   int error_cnt = 0, num_checks = 0;
   always #4 ref_clk = ~ref_clk;
   pwg_host pwg_host_i (.ref_clk(ref_clk), .read_data(read_data),
      .write_accepted(write_accepted), .cmd_write(cmd_write), .cmd_code(cmd_code),
      .cmd_data(cmd_data), .read_code(read_code));
   pwg_guard pwg_guard_i (.ref_clk(ref_clk), .reset(reset), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_data(cmd_data), .read_code(read_code),
      .read_data(read_data), .write_accepted(write_accepted), .write_rejected(write_rejected),
      .default_permit_map(dmap), .user_permit_map(umap), .default_private_pw(dpw),
      .user_private_pw(upw), .user_public_pw(ppw), .undervolt_pin(pin), .recovered_pin(rec),
      .commanded_off(cmd_off), .other_fault(1'b0), .output_enable(output_enable),
      .alert_output_n(alert_output_n), .undervolt_fault_status(undervolt_fault_status));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task automatic wr(input logic [7:0] c, input logic [71:0] d, input logic exp);
      logic acc;
      pwg_host_i.write(c, d, acc);
      check({7'h00, acc}, {7'h00, exp});
   endtask : wr
   task automatic rd(input logic [7:0] c, input logic [7:0] exp);
      logic [7:0] v;
      pwg_host_i.read(c, v);
      check(v, exp);
   endtask : rd
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : hold
   // flags packed as status, alert, enable
   function automatic logic [7:0] flags();
      return {5'h00, undervolt_fault_status, alert_output_n, output_enable};
   endfunction : flags
   // bounded wait, a hang ends the run
   task automatic wait_oe(input logic lvl);
      int i;
      for (i = 0; i < 20 && output_enable !== lvl; i++) hold(1);
      if (i == 20) begin
         error_cnt++;
         complete_run();
      end
   endtask : wait_oe
   initial begin
      // vendor keeps this command behind the default map
      dmap[cmd_monitor_undervolt] = 1'b0;
      hold(8);
      reset = 1'b0;
      rd(cmd_monitor_undervolt, uv_response_reset);
      rd(cmd_access_tier, access_tier_reset);
      check(flags(), 8'h03);
      wr(cmd_access_tier, 72'h0, 1'b0);
      rd(cmd_access_tier, 8'h01);
      pin = 1'b1;
      wait_oe(1'b0);
      hold(3);
      check(flags(), 8'h04);
      pin = 1'b0;
      hold(20);
      check(flags(), 8'h04);
      // recovery starts the retry delay, far longer than this run
      rec = 1'b1;
      hold(20);
      check(flags(), 8'h04);
      cmd_off = 1'b1;
      hold(1);
      cmd_off = 1'b0;
      hold(3);
      check(flags(), 8'h04);
      wr(cmd_clear_faults, 72'h0, 1'b1);
      check(flags(), 8'h03);
      rd(cmd_monitor_undervolt, 8'hbf);
      wr(cmd_monitor_undervolt, 72'h80, 1'b0);
      rd(cmd_monitor_undervolt, 8'hbf);
      wr(cmd_private_password, upw, 1'b1);
      rd(cmd_access_tier, tier_user);
      wr(cmd_monitor_undervolt, 72'h80, 1'b0);
      wr(cmd_private_password, dpw, 1'b1);
      rd(cmd_access_tier, tier_vendor);
      wr(cmd_private_password, upw, 1'b1);
      rd(cmd_access_tier, tier_vendor);
      wr(cmd_monitor_undervolt, 72'h80, 1'b1);
      rd(cmd_monitor_undervolt, 8'h80);
      pin = 1'b1;
      wait_oe(1'b0);
      hold(2);
      pin = 1'b0;
      rec = 1'b1;
      hold(20);
      check(flags(), 8'h04);
      wr(cmd_clear_faults, 72'h0, 1'b1);
      check(flags(), 8'h03);
      wr(cmd_public_password, {40'h0, ppw}, 1'b1);
      rd(cmd_access_tier, tier_public);
      wr(cmd_public_password, {40'h0, ~ppw}, 1'b1);
      rd(cmd_access_tier, tier_locked);
      rd(cmd_monitor_undervolt, 8'h80);
      dmap = '1;
      umap[cmd_monitor_undervolt] = 1'b0;
      wr(cmd_monitor_undervolt, 72'hc0, 1'b0);
      wr(cmd_public_password, {40'h0, ppw}, 1'b1);
      wr(cmd_monitor_undervolt, 72'hc0, 1'b0);
      wr(cmd_private_password, upw, 1'b1);
      wr(cmd_monitor_undervolt, 72'hc0, 1'b1);
      rec = 1'b0;
      pin = 1'b1;
      wait_oe(1'b0);
      hold(6);
      pin = 1'b0;
      hold(10);
      check(flags(), 8'h04);
      rec = 1'b1;
      wait_oe(1'b1);
      wr(cmd_clear_faults, 72'h0, 1'b1);
      wr(cmd_monitor_undervolt, 72'h00, 1'b1);
      pin = 1'b1;
      hold(10);
      check(flags(), 8'h03);
      pin = 1'b0;
      // let the synchronised level settle before a live response returns
      hold(4);
      umap = '1;
      dmap[8'hf8] = 1'b0;
      wr(cmd_public_password, {40'h0, ppw}, 1'b1);
      wr(cmd_monitor_undervolt, 72'hbf, 1'b1);
      rd(cmd_monitor_undervolt, 8'hbf);
      complete_run();
   end
endmodule : tb_top
